// ==== verilog/ldcc_pkg.sv ====
// Constants, field positions and types of the LED driver configuration block.
// Assumes a single 100 MHz system clock; the serial link is sampled, not clocked.
package ldcc_pkg;

   // ------------------------------------------------------------
   // Sizes and timing
   // ------------------------------------------------------------
   localparam int          WORD_W       = 16;
   localparam int          NUM_CH       = 16;
   localparam int          KEY_CNT_W    = 5;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          CH_DELAY_NS  = 10;
   // Least time per channel step, rounded up, never below one cycle
   localparam int          CH_DELAY_CYC_RAW = (CH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CH_DELAY_CYC = (CH_DELAY_CYC_RAW < 1) ? 1 : CH_DELAY_CYC_RAW;

   // ------------------------------------------------------------
   // Configuration word: reset value and field positions
   // ------------------------------------------------------------
   localparam logic [15:0] CFG_RESET    = 16'h0000;
   localparam int          GAIN_LSB     = 0;
   localparam int          GAIN_MSB     = 5;
   localparam int          RANGE_BIT    = 6;
   localparam int          DET_OFF_BIT  = 7;
   localparam int          THR_LSB      = 8;
   localparam int          THR_MSB      = 9;
   localparam int          AUTO_PD_BIT  = 10;
   localparam int          SLEW_LSB     = 11;
   localparam int          SLEW_MSB     = 12;
   localparam int          SDO_FALL_BIT = 13;
   localparam int          NO_DELAY_BIT = 14;
   localparam int          PWM12_BIT    = 15;

   // ------------------------------------------------------------
   // Keys: clock rising edges counted while the latch strobe is high
   // ------------------------------------------------------------
   localparam logic [4:0]  KEY_SWITCH   = 5'h01;
   localparam logic [4:0]  KEY_DET_END  = 5'h03;
   localparam logic [4:0]  KEY_CFG_WR   = 5'h07;
   localparam logic [4:0]  KEY_DET_OPEN = 5'h09;
   localparam logic [4:0]  KEY_DET_SHRT = 5'h0a;
   localparam logic [4:0]  KEY_DET_COMB = 5'h0b;
   localparam logic [4:0]  KEY_CNT_MAX  = 5'h1f;

   typedef enum logic [1:0] {
      DET_IDLE,
      DET_OPEN,
      DET_SHORT,
      DET_COMB
   } ldcc_det_type;

endpackage

// ==== verilog/ldcc_sync.sv ====
// Two-flop synchroniser for a group of unrelated level inputs.
// Assumes each bit is a slow level or a pin; no bus coherence is given.
`timescale 1ns/1ps
module ldcc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// ==== verilog/ldcc_top.sv ====
// Configuration word, key decoder, diagnostics and serial readout of a
// 16-channel constant-current LED driver.
// Assumes the serial link clock, data, strobe and analog fault flags are
// asynchronous to mclk, and that the link clock is well below mclk / 4.
//
// How it works
// RQ1: The configuration word is all zero after reset.
// RQ2: Host sends full 16-bit words, bit 0 least significant, bit 15 most.
// RQ3: Bit 14 zero staggers channel turn-on by 10 ns each; one means none.
// RQ4: Bit 15 chooses 16-bit (zero) or 12-bit (one) PWM counting.
// RQ5: Bits 0 to 5 are the unsigned 64-step current gain code.
// RQ6: Bit 6 chooses low range (ratio 28) or high range (ratio 80).
// RQ7: Error detection runs only while bit 7 is zero.
// RQ8: Host enables the tested channel and gives it nonzero brightness first.
// RQ9: Host keeps the channel on at least 1 us between start and end keys.
// RQ10: After detection end, 16 result bits leave channel 15 first; zero is faulty.
// RQ11: Key of 9, 10 or 11 edges starts open, short or combined detection.
// RQ12: Open test flags a channel whose current is at most half programmed.
// RQ13: Short test flags a channel reaching the threshold chosen by bits 9 and 8.
// RQ14: Combined test checks both open current and short voltage.
// RQ15: With bit 10 set, all-zero switch data shuts down, any one wakes.
// RQ16: While shut down, only channel switch latches are obeyed.
// RQ17: Bits 12 and 11 choose output rise and fall time.
// RQ18: Bit 13 set moves serial output changes to the falling clock edge.
// RQ19: Serial data is sampled each rising edge; strobe-high edges form the key.
// RQ20: The word updates all sixteen bits at once when the write key ends.
`timescale 1ns/1ps
module ldcc_top
   import ldcc_pkg::*;
#(
   parameter int NCH = ldcc_pkg::NUM_CH
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset,
   // Serial link pins
   input  wire logic                 serial_clk_pin,
   input  wire logic                 serial_in_pin,
   input  wire logic                 latch_strobe,
   output logic                      serial_out_pin,
   // Analog fault comparators per channel
   input  wire logic [NCH-1:0]       current_low_in,
   input  wire logic [NCH-1:0]       voltage_high_in,
   // Settings to the analog and PWM sections
   output logic [5:0]                gain_code,
   output logic                      high_range,
   output logic [1:0]                short_thresh_sel,
   output logic [1:0]                slew_sel,
   output logic                      pwm_12bit,
   output logic                      power_down,
   output logic [NCH-1:0]            channel_on,
   output ldcc_pkg::ldcc_det_type    det_mode
);
   import ldcc_pkg::*;

   // ------------------------------------------------------------
   // Input synchronisation and edge detection
   // ------------------------------------------------------------
   logic [2*NCH+2:0] sync_vec;
   logic             sclk_s;
   logic             sdi_s;
   logic             le_s;
   logic [NCH-1:0]   cur_low_s;
   logic [NCH-1:0]   volt_high_s;
   logic             sclk_d_ff;
   logic             le_d_ff;

   ldcc_sync #(
      .WIDTH (2*NCH+3)
   ) u_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in ({voltage_high_in, current_low_in, latch_strobe, serial_in_pin,
                  serial_clk_pin}),
      .sync_out (sync_vec)
   );

   assign {volt_high_s, cur_low_s, le_s, sdi_s, sclk_s} = sync_vec;

   always_ff @(posedge mclk) begin
      if (reset) begin
         sclk_d_ff <= 1'b0;
         le_d_ff   <= 1'b0;
      end else begin
         sclk_d_ff <= sclk_s;
         le_d_ff   <= le_s;
      end
   end

   wire sclk_rise = sclk_s & ~sclk_d_ff;
   wire sclk_fall = ~sclk_s & sclk_d_ff;
   wire le_fall   = le_d_ff & ~le_s;

   // ------------------------------------------------------------
   // Key counter and decode
   // ------------------------------------------------------------
   logic [KEY_CNT_W-1:0] key_cnt_ff;
   logic [WORD_W-1:0]    shreg_ff;
   logic [WORD_W-1:0]    cfg_ff;
   logic [NCH-1:0]       sw_ff;
   logic                 pd_ff;
   ldcc_det_type         det_ff;

   wire key_sw    = le_fall & (key_cnt_ff == KEY_SWITCH);
   // Shutdown blocks everything but the switch latch
   wire key_ok    = le_fall & ~pd_ff; // RQ16
   wire key_cfg   = key_ok & (key_cnt_ff == KEY_CFG_WR);
   wire det_allow = key_ok & ~cfg_ff[DET_OFF_BIT]; // RQ7
   wire key_open  = det_allow & (key_cnt_ff == KEY_DET_OPEN);
   wire key_short = det_allow & (key_cnt_ff == KEY_DET_SHRT);
   wire key_comb  = det_allow & (key_cnt_ff == KEY_DET_COMB);
   wire key_end   = key_ok & (key_cnt_ff == KEY_DET_END) & (det_ff != DET_IDLE);

   // Saturate so that long strobes never alias onto a short key
   wire [KEY_CNT_W-1:0] cnt_inc = (key_cnt_ff == KEY_CNT_MAX) ? key_cnt_ff :
                                  key_cnt_ff + 5'h01;

   always_ff @(posedge mclk) begin
      if (reset) begin
         key_cnt_ff <= '0;
      end else if (le_fall) begin
         key_cnt_ff <= '0;
      end else if (sclk_rise & le_s) begin
         key_cnt_ff <= cnt_inc; // RQ19
      end
   end

   // ------------------------------------------------------------
   // Diagnostics
   // ------------------------------------------------------------
   wire [NCH-1:0] fault = (det_ff == DET_OPEN)  ? cur_low_s : // RQ12
                          (det_ff == DET_SHORT) ? volt_high_s : // RQ13
                          (det_ff == DET_COMB)  ? (cur_low_s | volt_high_s) : '0; // RQ14

   // A zero marks a faulty channel
   wire [WORD_W-1:0] result = ~fault; // RQ10

   always_ff @(posedge mclk) begin
      if (reset) begin
         det_ff <= DET_IDLE;
      end else if (key_open) begin
         det_ff <= DET_OPEN; // RQ11
      end else if (key_short) begin
         det_ff <= DET_SHORT; // RQ11
      end else if (key_comb) begin
         det_ff <= DET_COMB; // RQ11
      end else if (key_end) begin
         det_ff <= DET_IDLE;
      end
   end
   property p_det_block;
      @(posedge mclk) disable iff (reset)
         (le_fall && cfg_ff[DET_OFF_BIT] && key_cnt_ff == KEY_DET_OPEN)
         |=> (det_ff == $past(det_ff));
   endproperty
   a_det_block: assert property (p_det_block) else $error("detection started while off"); // RQ7
   property p_det_start;
      @(posedge mclk) disable iff (reset)
         (le_fall && !pd_ff && !cfg_ff[DET_OFF_BIT] && key_cnt_ff == KEY_DET_SHRT)
         |=> (det_ff == DET_SHORT);
   endproperty
   a_det_start: assert property (p_det_start) else $error("short detection not started"); // RQ11

   // ------------------------------------------------------------
   // Shift register and serial output
   // ------------------------------------------------------------
   logic              sdo_ff;
   wire  [WORD_W-1:0] nxt_shreg = key_end   ? result : // RQ10
                                  sclk_rise ? {shreg_ff[WORD_W-2:0], sdi_s} : // RQ19
                                  shreg_ff;

   wire sdo_upd = key_end | (cfg_ff[SDO_FALL_BIT] ? sclk_fall : sclk_rise); // RQ18

   always_ff @(posedge mclk) begin
      if (reset) begin
         shreg_ff <= '0;
         sdo_ff   <= 1'b0;
      end else begin
         shreg_ff <= nxt_shreg;
         if (sdo_upd) begin
            sdo_ff <= nxt_shreg[WORD_W-1];
         end
      end
   end
   property p_result;
      @(posedge mclk) disable iff (reset)
         key_end |=> (shreg_ff == ~$past(fault)) && (serial_out_pin == shreg_ff[WORD_W-1]);
   endproperty
   a_result: assert property (p_result) else $error("result not loaded"); // RQ10
   property p_sdo_fall;
      @(posedge mclk) disable iff (reset)
         (cfg_ff[SDO_FALL_BIT] && !sclk_fall && !key_end) |=> $stable(serial_out_pin);
   endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved off falling edge"); // RQ18
   property p_shift;
      @(posedge mclk) disable iff (reset)
         (sclk_rise && !key_end) |=> (shreg_ff == {$past(shreg_ff[WORD_W-2:0]), $past(sdi_s)});
   endproperty
   a_shift: assert property (p_shift) else $error("serial shift wrong"); // RQ19

   // ------------------------------------------------------------
   // Configuration word, channel switch and auto shutdown
   // ------------------------------------------------------------
   // The whole word lands at once; a partial shift never shows
   always_ff @(posedge mclk) begin
      if (reset) begin
         cfg_ff <= CFG_RESET; // RQ1
      end else if (key_cfg) begin
         cfg_ff <= shreg_ff; // RQ20
      end
   end
   property p_reset_zero;
      @(posedge mclk) reset |=> (cfg_ff == CFG_RESET);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("cfg not zero after reset"); // RQ1
   property p_cfg_load;
      @(posedge mclk) disable iff (reset) key_cfg |=> (cfg_ff == $past(shreg_ff));
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("cfg not loaded by key"); // RQ20
   property p_cfg_hold;
      @(posedge mclk) disable iff (reset) !key_cfg |=> $stable(cfg_ff);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed without key"); // RQ16

   always_ff @(posedge mclk) begin
      if (reset) begin
         sw_ff <= '0;
         pd_ff <= 1'b0;
      end else begin
         if (key_sw) begin
            sw_ff <= shreg_ff[NCH-1:0];
         end
         if (~cfg_ff[AUTO_PD_BIT]) begin
            pd_ff <= 1'b0;
         end else if (key_sw) begin
            pd_ff <= (shreg_ff[NCH-1:0] == '0); // RQ15
         end
      end
   end
   property p_shutdown;
      @(posedge mclk) disable iff (reset)
         (key_sw && cfg_ff[AUTO_PD_BIT]) |=> (pd_ff == ($past(shreg_ff[NCH-1:0]) == '0));
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("auto shutdown wrong"); // RQ15

   // ------------------------------------------------------------
   // Gradual turn-on: tap k holds the switch word k+1 cycles late
   // ------------------------------------------------------------
   localparam int DLY_DEPTH = (NCH - 1) * CH_DELAY_CYC;
   logic [NCH-1:0] dly_ff [DLY_DEPTH];

   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int k = 0; k < DLY_DEPTH; k++) begin
            dly_ff[k] <= '0;
         end
      end else begin
         dly_ff[0] <= sw_ff;
         for (int k = 1; k < DLY_DEPTH; k++) begin
            dly_ff[k] <= dly_ff[k-1];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         if (gi == 0) begin : g_first
            assign channel_on[gi] = sw_ff[gi];
         end else begin : g_rest
            assign channel_on[gi] = cfg_ff[NO_DELAY_BIT] ? sw_ff[gi] :
                                    dly_ff[gi*CH_DELAY_CYC-1][gi]; // RQ3
         end
      end
   endgenerate
   property p_gradual;
      @(posedge mclk) disable iff (reset)
         (!cfg_ff[NO_DELAY_BIT] && !$past(reset, 3)) |-> (channel_on[3] == $past(sw_ff[3], 3));
   endproperty
   a_gradual: assert property (p_gradual) else $error("channel 3 delay wrong"); // RQ3

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign gain_code        = cfg_ff[GAIN_MSB:GAIN_LSB]; // RQ5
   assign high_range       = cfg_ff[RANGE_BIT]; // RQ6
   assign short_thresh_sel = cfg_ff[THR_MSB:THR_LSB]; // RQ13
   assign slew_sel         = cfg_ff[SLEW_MSB:SLEW_LSB]; // RQ17
   assign pwm_12bit        = cfg_ff[PWM12_BIT]; // RQ4
   assign power_down       = pd_ff;
   assign det_mode         = det_ff;
   assign serial_out_pin   = sdo_ff;

endmodule

// ==== test/ldcc_host_model.sv ====
// Host model for the serial link: shifts words and keys in, reads results out.
// Assumes the block samples these pins with its own much faster clock.
`timescale 1ns/1ps
module ldcc_host_model (
   // Link outputs
   output logic      serial_clk_pin,
   output logic      serial_in_pin,
   output logic      latch_strobe,
   // Link input
   input  wire logic serial_out_pin
);
   localparam realtime HALF = 62.5;

   initial begin
      serial_clk_pin = 1'b0;
      serial_in_pin  = 1'b0;
      latch_strobe   = 1'b0;
   end

   // Link clock rests low outside frames
   task automatic pulse();
      #HALF serial_clk_pin = 1'b1;
      #HALF serial_clk_pin = 1'b0;
   endtask

   // Whole word, first bit is the top one; strobe high on the last edges
   task automatic send(input logic [15:0] word, input int key_len);
      for (int i = 15; i >= 0; i--) begin
         serial_in_pin = word[i];
         latch_strobe  = (i < key_len);
         pulse();
      end
      #HALF latch_strobe = 1'b0;
      // Released data line must not look like it still holds the last bit
      serial_in_pin = ~serial_in_pin;
   endtask

   // Sample just before the edge that would move the output on
   task automatic read(input logic fall, output logic [15:0] word);
      for (int i = 15; i >= 0; i--) begin
         #HALF;
         if (!fall) word[i] = serial_out_pin;
         serial_clk_pin = 1'b1;
         #HALF;
         if (fall) word[i] = serial_out_pin;
         serial_clk_pin = 1'b0;
      end
   endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the configuration block and its serial link.
// Assumes the host model drives the link pins at a 125 ns link period.
`timescale 1ns/1ps
module tb;
   import ldcc_pkg::*;
   logic          mclk;
   logic          reset;
   logic          serial_clk_pin;
   logic          serial_in_pin;
   logic          latch_strobe;
   logic          serial_out_pin;
   logic [15:0]   current_low_in;
   logic [15:0]   voltage_high_in;
   logic [15:0]   channel_on;
   logic [5:0]    gain_code;
   logic [1:0]    short_thresh_sel;
   logic [1:0]    slew_sel;
   logic          high_range;
   logic          pwm_12bit;
   logic          power_down;
   ldcc_det_type  det_mode;
   int            failures = 0;
   int            checked = 0;

   ldcc_top #(.NCH(16)) ldcc_top_i (
      .mclk(mclk), .reset(reset), .serial_clk_pin(serial_clk_pin),
      .serial_in_pin(serial_in_pin), .latch_strobe(latch_strobe),
      .serial_out_pin(serial_out_pin), .current_low_in(current_low_in),
      .voltage_high_in(voltage_high_in), .gain_code(gain_code), .high_range(high_range),
      .short_thresh_sel(short_thresh_sel), .slew_sel(slew_sel), .pwm_12bit(pwm_12bit),
      .power_down(power_down), .channel_on(channel_on), .det_mode(det_mode));

   ldcc_host_model ldcc_host_model_i (
      .serial_clk_pin(serial_clk_pin), .serial_in_pin(serial_in_pin),
      .latch_strobe(latch_strobe), .serial_out_pin(serial_out_pin));

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Decode lands about three cycles after the strobe falls
   task automatic settle();
      repeat (8) @(posedge mclk);
      #1;
   endtask

   task automatic put(input logic [15:0] w, input int key);
      ldcc_host_model_i.send(w, key);
      settle();
   endtask

   // Bits 14, 13, 10 and 7 have no output of their own
   task automatic check_cfg(input logic [15:0] w);
      check({pwm_12bit, 2'b00, slew_sel, 1'b0, short_thresh_sel, 1'b0, high_range,
             gain_code}, w & 16'h9b7f);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check_cfg(16'h0000);
      check({14'h0, power_down, serial_out_pin}, 16'h0000);
      check(channel_on, 16'h0000);
      check({14'h0, det_mode}, {14'h0, DET_IDLE});
   endtask

   task automatic t_cfg();
      put(16'h916a, KEY_CFG_WR);
      check_cfg(16'h916a);
      put(16'h6e95, 5);
      check_cfg(16'h916a);
      put(16'h6e95, KEY_CFG_WR);
      check_cfg(16'h6e95);
   endtask

   task automatic t_autopd();
      put(16'h4400, KEY_CFG_WR);
      put(16'h0000, KEY_SWITCH);
      check({15'h0, power_down}, 16'h0001);
      put(16'h4401, KEY_CFG_WR);
      check_cfg(16'h4400);
      put(16'h0000, KEY_DET_OPEN);
      check({14'h0, det_mode}, {14'h0, DET_IDLE});
      put(16'h0010, KEY_SWITCH);
      check({15'h0, power_down}, 16'h0000);
      check(channel_on, 16'h0010);
      put(16'h4401, KEY_CFG_WR);
      check_cfg(16'h4401);
   endtask

   task automatic t_gradual();
      int n;
      put(16'h0000, KEY_CFG_WR);
      put(16'h0000, KEY_SWITCH);
      ldcc_host_model_i.send(16'hffff, KEY_SWITCH);
      n = 0;
      while (channel_on[0] !== 1'b1 && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      for (int k = 0; k < 16; k++) begin
         check(channel_on, 16'hffff >> (15 - k));
         @(posedge mclk);
         #1;
      end
      put(16'h4000, KEY_CFG_WR);
      ldcc_host_model_i.send(16'ha5c3, KEY_SWITCH);
      n = 0;
      while (channel_on === 16'hffff && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check(channel_on, 16'ha5c3);
   endtask

   task automatic t_detect();
      logic [4:0]   keys[3] = '{KEY_DET_OPEN, KEY_DET_SHRT, KEY_DET_COMB};
      ldcc_det_type modes[3] = '{DET_OPEN, DET_SHORT, DET_COMB};
      logic [15:0]  cur = 16'h0f31;
      logic [15:0]  volt = 16'h8c04;
      logic [15:0]  exp[3];
      logic [15:0]  res;
      exp = '{~cur, ~volt, ~(cur | volt)};
      put(16'h4080, KEY_CFG_WR);
      put(16'h0000, KEY_DET_OPEN);
      check({14'h0, det_mode}, {14'h0, DET_IDLE});
      @(posedge mclk);
      #1;
      current_low_in  = cur;
      voltage_high_in = volt;
      for (int m = 0; m < 3; m++) begin
         put(16'h4000 | (16'(m & 1) << 13), KEY_CFG_WR);
         put(16'hffff, KEY_SWITCH);
         put(16'h0000, int'(keys[m]));
         check({14'h0, det_mode}, {14'h0, modes[m]});
         repeat (110) @(posedge mclk);
         put(16'h0000, KEY_DET_END);
         ldcc_host_model_i.read(m[0], res);
         check(res, exp[m]);
      end
   endtask

   // A second reset in mid-run must clear the word and the switch state again
   task automatic t_reset_again();
      check(channel_on, 16'hffff);
      @(posedge mclk);
      #1 reset = 1'b1;
      repeat (3) @(posedge mclk);
      #1 reset = 1'b0;
      settle();
      t_reset();
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      reset           = 1'b1;
      current_low_in  = 16'h0000;
      voltage_high_in = 16'h0000;
      repeat (3) @(posedge mclk);
      #1 reset = 1'b0;
      settle();
      t_reset();
      t_cfg();
      t_autopd();
      t_gradual();
      t_detect();
      t_reset_again();
      report_and_stop();
   end

   // About 30 frames of 2 us plus waits; generous margin before a hang is called
   initial begin
      #300000;
      failures++;
      report_and_stop();
   end
endmodule
